// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench of the debug frame port with a data register model.
// Assumes: Address register 8 bits, data registers 16 bits.
// Notes:   A released data line shows the inverse of its last level.
`timescale 1ns/100ps
module tb_top
	import tdbg_pkg::*;
;
	// ==========================================================
	// Signals
	logic              sys_clk;
	logic              rstn;
	logic              clk_line;
	logic              dev_val;
	logic              dev_en;
	logic              claimed;
	logic              m_val;
	logic              m_en;
	logic              last_lvl;
	logic              line_lvl;
	logic [7:0]        dreg_addr;
	logic [LEN_W-1:0]  dreg_len;
	logic [15:0]       dreg_wdata;
	logic [15:0]       dreg_rdata;
	logic              dreg_wr;
	logic              dreg_rd;
	logic              dreg_ack;
	logic [15:0]       regs [256];
	logic [15:0]       seen_wdata;
	logic [7:0]        seen_addr;
	logic [LEN_W-1:0]  seen_len;
	logic              pend;
	logic              pend_wr;
	logic [31:0]       rv;
	int                zeros;
	int                n_errors;
	int                checks;
	int                ack_dly;
	int                cnt;

	tdbg_port #(.ADDR_W(8), .DREG_W(16)) tdbg_port_inst (.sys_clk(sys_clk), .rstn(rstn),
		.debug_clock_line(clk_line), .debug_data_line_in(line_lvl), .debug_data_line_out(dev_val),
		.debug_data_line_oe(dev_en), .debug_port_claimed(claimed), .dreg_addr(dreg_addr),
		.dreg_len(dreg_len), .dreg_wdata(dreg_wdata), .dreg_wr(dreg_wr), .dreg_rd(dreg_rd),
		.dreg_ack(dreg_ack), .dreg_rdata(dreg_rdata));
	tdbg_master #(.ADDR_W(8)) tdbg_master_inst (.debug_clock_line(clk_line), .drv_val(m_val),
		.drv_en(m_en), .line_lvl(line_lvl));

	// ==========================================================
	// Wire and data register model
	assign line_lvl = dev_en ? dev_val : (m_en ? m_val : ~last_lvl);
	always @(posedge clk_line) last_lvl <= line_lvl;
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		dreg_ack <= 1'b0;
		if (dev_en === 1'b1 && m_en === 1'b1) begin
			check("drive_overlap", 32'h0000_0001, 32'h0000_0000);
		end
		if (dev_en === 1'b1 && claimed !== 1'b1) begin
			check("claim_while_driving", {31'h0000_0000, claimed}, 32'h0000_0001);
		end
		if (!pend && (dreg_wr === 1'b1 || dreg_rd === 1'b1)) begin
			pend <= 1'b1;
			pend_wr <= dreg_wr;
			cnt <= ack_dly;
		end else if (pend && cnt > 0) begin
			cnt <= cnt - 1;
		end else if (pend) begin
			pend <= 1'b0;
			dreg_ack <= 1'b1;
			dreg_rdata <= regs[dreg_addr];
			if (pend_wr) begin
				regs[dreg_addr] <= dreg_wdata;
				seen_wdata <= dreg_wdata;
				seen_addr <= dreg_addr;
				seen_len <= dreg_len;
			end
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	task automatic xfer(input logic [1:0] instr, input logic [1:0] len, input logic [31:0] wv);
		tdbg_master_inst.frame(instr, len, wv, rv, zeros);
		check("wait_bound", {31'h0000_0000, zeros < 400}, 32'h0000_0001);
		check("oe_after_stop", {31'h0000_0000, dev_en}, 32'h0000_0000);
		check("claim_after_stop", {31'h0000_0000, claimed}, 32'h0000_0000);
		if (zeros >= 400) begin
			complete_run();
		end
	endtask : xfer

	// The link resets only while strobed, and two strobes after release are swallowed.
	task automatic do_reset;
		logic s;
		@(negedge sys_clk) rstn = 1'b0;
		repeat (4) tdbg_master_inst.strobe(1'b0, 1'b0, s);
		@(negedge sys_clk) rstn = 1'b1;
		repeat (2) tdbg_master_inst.strobe(1'b0, 1'b0, s);
	endtask : do_reset

	// ==========================================================
	// Scenarios
	task automatic t_addr;
		xfer(TDBG_INSTR_ADDR_WR, 2'h0, 32'h0000_00A5);
		xfer(TDBG_INSTR_ADDR_RD, 2'h0, 32'h0000_0000);
		check("addr_readback", rv, 32'h0000_00A5);
		$display("test addr done");
	endtask : t_addr

	task automatic t_reset;
		do_reset();
		xfer(TDBG_INSTR_ADDR_RD, 2'h0, 32'h0000_0000);
		check("addr_after_reset", rv, 32'h0000_0000);
		xfer(TDBG_INSTR_DATA_RD, 2'h0, 32'h0000_0000);
		check("id_read", rv, 32'h0000_0096);
		$display("test reset done");
	endtask : t_reset

	task automatic t_write;
		xfer(TDBG_INSTR_ADDR_WR, 2'h0, 32'h0000_005C);
		ack_dly = 200;
		xfer(TDBG_INSTR_DATA_WR, 2'h0, 32'h0000_00C3);
		check("slow_wait", {31'h0000_0000, zeros > 15}, 32'h0000_0001);
		check("wr_addr", {24'h00_0000, seen_addr}, 32'h0000_005C);
		check("wr_len", {30'h0000_0000, seen_len}, 32'h0000_0000);
		check("wr_short", {16'h0000, seen_wdata}, 32'h0000_C300);
		ack_dly = 1;
		xfer(TDBG_INSTR_DATA_WR, 2'h1, 32'h0000_BEEF);
		check("wr_full", {16'h0000, seen_wdata}, 32'h0000_BEEF);
		xfer(TDBG_INSTR_DATA_WR, 2'h2, 32'h0012_3456);
		check("wr_long", {16'h0000, seen_wdata}, 32'h0000_1234);
		check("wr_len2", {30'h0000_0000, seen_len}, 32'h0000_0002);
		$display("test write done");
	endtask : t_write

	task automatic t_read;
		ack_dly = 200;
		xfer(TDBG_INSTR_DATA_RD, 2'h0, 32'h0000_0000);
		check("rd_slow_wait", {31'h0000_0000, zeros > 15}, 32'h0000_0001);
		check("rd_short", rv, 32'h0000_0034);
		ack_dly = 0;
		xfer(TDBG_INSTR_DATA_RD, 2'h1, 32'h0000_0000);
		check("rd_full", rv, 32'h0000_1234);
		xfer(TDBG_INSTR_DATA_RD, 2'h3, 32'h0000_0000);
		check("rd_long", rv, 32'h0000_1234);
		$display("test read done");
	endtask : t_read

	// ==========================================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		last_lvl = 1'b0;
		dreg_ack = 1'b0;
		dreg_rdata = 16'h0000;
		pend = 1'b0;
		pend_wr = 1'b0;
		n_errors = 0;
		checks = 0;
		ack_dly = 1;
		cnt = 0;
		foreach (regs[i]) regs[i] = 16'h0000;
		regs[0] = 16'h3C96; // Identification value is arbitrary.
		repeat (3) @(negedge sys_clk);
		do_reset();
		t_addr();
		t_reset();
		t_write();
		t_read();
		complete_run();
	end
endmodule : tb_top

// ---- tb/tdbg_master.sv ----
// Purpose: Behavioural master of the two-wire debug link.
// Assumes: Link period 48 ns; the clock line stands high between frames.
// Notes:   Device bits are sampled late in the high phase, well after they change.
`timescale 1ns/100ps
module tdbg_master
	import tdbg_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Link pins
	output logic      debug_clock_line,
	output logic      drv_val,
	output logic      drv_en,
	input  wire logic line_lvl
);
	// ==========================================================
	// Strobes and fields
	initial begin
		debug_clock_line = 1'b1;
		drv_val = 1'b0;
		drv_en = 1'b0;
	end

	// Data is changed only at the start of a strobe, long after the last rising edge.
	task automatic strobe(input logic d, input logic en, output logic s);
		drv_en = en;
		drv_val = d;
		#2;
		debug_clock_line = 1'b0;
		#22;
		debug_clock_line = 1'b1;
		#22;
		s = line_lvl;
		#2;
	endtask : strobe

	task automatic send(input logic [31:0] v, input int n);
		logic s;
		for (int i = 0; i < n; i++) begin
			strobe(v[i], 1'b1, s);
		end
	endtask : send

	task automatic recv(output logic [31:0] v, input int n);
		logic s;
		v = 32'h0000_0000;
		for (int i = 0; i < n; i++) begin
			strobe(1'b0, 1'b0, s);
			v[i] = s;
		end
	endtask : recv

	// Bounded so that a device that never ends its wait cannot hang the run.
	task automatic wait_field(output int zeros);
		logic s;
		zeros = 0;
		s = 1'b0;
		while (s !== 1'b1 && zeros < 400) begin
			strobe(1'b0, 1'b0, s);
			if (s !== 1'b1) begin
				zeros++;
			end
		end
	endtask : wait_field

	task automatic frame(input logic [1:0] instr, input logic [1:0] len, input logic [31:0] wv,
		output logic [31:0] rv, output int zeros);
		logic s;
		rv = 32'h0000_0000;
		zeros = 0;
		strobe(1'b0, 1'b0, s);
		send({30'h0000_0000, instr}, 2);
		if (instr == TDBG_INSTR_ADDR_WR) begin
			send(wv, ADDR_W);
		end else if (instr == TDBG_INSTR_ADDR_RD) begin
			recv(rv, ADDR_W);
		end else begin
			send({30'h0000_0000, len}, 2);
			if (instr == TDBG_INSTR_DATA_WR) begin
				send(wv, 8 * (len + 1));
				wait_field(zeros);
			end else begin
				wait_field(zeros);
				recv(rv, 8 * (len + 1));
			end
		end
		strobe(1'b0, 1'b0, s);
	endtask : frame
endmodule : tdbg_master

// ---- verilog/tdbg_access.sv ----
// Purpose: System-clock side of a data register access requested by the link.
// Assumes: Link-side request fields stay stable while a request is pending.
// Notes:   Acknowledge may come in the same cycle as the strobe.
`timescale 1ns/100ps
module tdbg_access
	import tdbg_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int DREG_W = 8
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	// Request from and response to the link domain
	input  wire logic              req_sync,
	input  wire logic              req_is_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [LEN_W-1:0]  req_len,
	input  wire logic [DREG_W-1:0] req_wdata,
	output logic                   ack_tgl,
	output logic [DREG_W-1:0]      rdata_hold,
	// Data register port
	output logic [ADDR_W-1:0]      dreg_addr,
	output logic [LEN_W-1:0]       dreg_len,
	output logic [DREG_W-1:0]      dreg_wdata,
	output logic                   dreg_wr,
	output logic                   dreg_rd,
	input  wire logic              dreg_ack,
	input  wire logic [DREG_W-1:0] dreg_rdata
);

	typedef struct packed {
		tdbg_astate_e      st;
		logic              seen;
		logic              ack;
		logic              wr;
		logic              rd;
		logic              is_rd;
		logic [ADDR_W-1:0] addr;
		logic [LEN_W-1:0]  len;
		logic [DREG_W-1:0] wdata;
		logic [DREG_W-1:0] rdata;
	} tdbg_acc_s;

	tdbg_acc_s cur_reg;
	tdbg_acc_s cur_next;

	always_comb begin
		cur_next    = cur_reg;
		cur_next.wr = 1'b0;
		cur_next.rd = 1'b0;
		unique case (cur_reg.st)
			A_IDLE: begin
				if (req_sync != cur_reg.seen) begin
					cur_next.seen  = req_sync;
					cur_next.addr  = req_addr;
					cur_next.len   = req_len;
					cur_next.wdata = req_wdata;
					cur_next.wr    = req_is_write;     // see RQ13
					cur_next.rd    = !req_is_write;    // see RQ15
					cur_next.is_rd = !req_is_write;
					cur_next.st    = A_BUSY;
				end
			end
			A_BUSY: begin
				if (dreg_ack) begin
					if (cur_reg.is_rd) begin
						cur_next.rdata = dreg_rdata;
					end
					// Toggling only after the write is acknowledged holds the wait field low.
					cur_next.ack = !cur_reg.ack;       // see RQ9
					cur_next.st  = A_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cur_reg       <= '0;
			cur_reg.st    <= A_IDLE;
			cur_reg.len   <= LEN_RST;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign ack_tgl    = cur_reg.ack;
	assign rdata_hold = cur_reg.rdata;
	assign dreg_addr  = cur_reg.addr;
	assign dreg_len   = cur_reg.len;
	assign dreg_wdata = cur_reg.wdata;
	assign dreg_wr    = cur_reg.wr;
	assign dreg_rd    = cur_reg.rd;

	// ==========================================================
	// Assertions
	a_strobe_single: assert property (@(posedge sys_clk) disable iff (!rstn) // see RQ13
		(dreg_wr || dreg_rd) |=> !(dreg_wr || dreg_rd))
		else $error("Register strobe lasted more than one cycle.");

	a_ack_completes: assert property (@(posedge sys_clk) disable iff (!rstn) // see RQ9
		(cur_reg.st == A_BUSY && dreg_ack) |=> (ack_tgl != $past(ack_tgl)) && cur_reg.st == A_IDLE)
		else $error("Acknowledge did not complete the access.");

endmodule : tdbg_access

// ---- verilog/tdbg_pkg.sv ----
// Purpose: Shared constants and types for the two-wire debug frame port.
// Assumes: Data registers are at most 32 bits wide.
// Notes:   The rule summary below applies to every file of the block.
//
// Summary of operation
// RQ1: Master opens each frame with a start strobe.
// RQ2: Two-bit instruction follows start, selects frame type.
// RQ3: Stop strobe ends frame; pin released on it.
// RQ4: Length field gives byte count minus one.
// RQ5: Address field width equals address register width.
// RQ6: Reset clears address register, selecting identification register.
// RQ7: Data field is whole bytes set by length.
// RQ8: Device sends zeros then one terminating wait bit.
// RQ9: Write wait ends only after register write completes.
// RQ10: Every field travels least significant bit first.
// RQ11: Address write loads the address register.
// RQ12: Address read returns the address register.
// RQ13: Data write stores into the selected register.
// RQ14: Written field aligns to the register's top bits.
// RQ15: Data read returns the selected register.
// RQ16: Codes: 00 read, 01 write, 10/11 address.
// RQ17: Read wait ends once the value is fetched.
// RQ18: Read data is right-justified in the field.
// RQ19: Field order fixed for data write and read.
// RQ20: Device drives only wait and returned fields.
package tdbg_pkg;

	// ==========================================================
	// Field sizes
	localparam int SHIFT_W   = 32;
	localparam int INSTR_W   = 2;
	localparam int LEN_W     = 2;
	localparam int CNT_W     = 6;
	localparam int BYTE_BITS = 8;

	// ==========================================================
	// Reset values
	localparam logic [SHIFT_W-1:0] SHIFT_RST = 32'h0000_0000;
	localparam logic [CNT_W-1:0]   CNT_RST   = 6'h00;
	localparam logic [INSTR_W-1:0] INSTR_RST = 2'h0;
	localparam logic [LEN_W-1:0]   LEN_RST   = 2'h0;

	// ==========================================================
	// Instruction codes and state machines
	typedef enum logic [1:0] {
		TDBG_INSTR_DATA_RD = 2'b00,
		TDBG_INSTR_DATA_WR = 2'b01,
		TDBG_INSTR_ADDR_RD = 2'b10,
		TDBG_INSTR_ADDR_WR = 2'b11
	} tdbg_instr_e;

	typedef enum logic [3:0] {
		L_IDLE    = 4'b0000,
		L_INSTR   = 4'b0001,
		L_LEN     = 4'b0010,
		L_ADDR_WR = 4'b0011,
		L_ADDR_RD = 4'b0100,
		L_DATA_WR = 4'b0101,
		L_WAIT    = 4'b0110,
		L_DATA_RD = 4'b0111,
		L_STOP    = 4'b1000
	} tdbg_lstate_e;

	typedef enum logic [0:0] {
		A_IDLE = 1'b0,
		A_BUSY = 1'b1
	} tdbg_astate_e;

endpackage : tdbg_pkg

// ---- verilog/tdbg_port.sv ----
// Purpose: Target-side frame engine of the two-wire debug link.
// Assumes: Data and instruction bits are sampled on the rising link clock edge.
// Notes:   The link clock stands still between frames; link state resets only
//          while the link clock runs, so the master strobes during reset.
`timescale 1ns/100ps
module tdbg_port
	import tdbg_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int DREG_W = 8
) (
	// System clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	// Debug link pins
	input  wire logic              debug_clock_line,
	input  wire logic              debug_data_line_in,
	output logic                   debug_data_line_out,
	output logic                   debug_data_line_oe,
	output logic                   debug_port_claimed,
	// Data register port
	output logic [ADDR_W-1:0]      dreg_addr,
	output logic [LEN_W-1:0]       dreg_len,
	output logic [DREG_W-1:0]      dreg_wdata,
	output logic                   dreg_wr,
	output logic                   dreg_rd,
	input  wire logic              dreg_ack,
	input  wire logic [DREG_W-1:0] dreg_rdata
);

	// ==========================================================
	// Link-domain state
	typedef struct packed {
		tdbg_lstate_e       st;
		logic [INSTR_W-1:0] instr;
		logic [LEN_W-1:0]   len;
		logic [CNT_W-1:0]   cnt;
		logic [SHIFT_W-1:0] sreg;
		logic [ADDR_W-1:0]  addr;
		logic               req;
		logic               dout;
		logic               oe;
		logic               claimed;
	} tdbg_link_s;

	tdbg_link_s cur_reg;
	tdbg_link_s cur_next;

	logic              link_rstn;
	logic              ack_sync;
	logic              req_sync;
	logic              ack_tgl;
	logic [DREG_W-1:0] rdata_hold;
	logic              done;
	logic [CNT_W-1:0]  last_bit;
	logic [INSTR_W-1:0] instr_full;
	logic [LEN_W-1:0]  len_full;
	logic [SHIFT_W-1:0] sreg_in;
	logic [DREG_W-1:0] link_wdata;
	logic              sreg_lsb;
	logic              req_w;
	logic [DREG_W-1:0] sreg_low;

	// ==========================================================
	// Clock crossings
	// The reset synchroniser itself cannot be reset; it settles within two link edges.
	tdbg_sync u_rst_sync (
		.clk   (debug_clock_line),
		.rst_n (1'b1),
		.d     (rstn),
		.q     (link_rstn)
	);

	tdbg_sync u_ack_sync (
		.clk   (debug_clock_line),
		.rst_n (link_rstn),
		.d     (ack_tgl),
		.q     (ack_sync)
	);

	tdbg_sync u_req_sync (
		.clk   (sys_clk),
		.rst_n (rstn),
		.d     (cur_reg.req),
		.q     (req_sync)
	);

	tdbg_access #(
		.ADDR_W (ADDR_W),
		.DREG_W (DREG_W)
	) u_access (
		.sys_clk      (sys_clk),
		.rstn         (rstn),
		.req_sync     (req_sync),
		.req_is_write (cur_reg.instr == TDBG_INSTR_DATA_WR),
		.req_addr     (cur_reg.addr),
		.req_len      (cur_reg.len),
		.req_wdata    (link_wdata),
		.ack_tgl      (ack_tgl),
		.rdata_hold   (rdata_hold),
		.dreg_addr    (dreg_addr),
		.dreg_len     (dreg_len),
		.dreg_wdata   (dreg_wdata),
		.dreg_wr      (dreg_wr),
		.dreg_rd      (dreg_rd),
		.dreg_ack     (dreg_ack),
		.dreg_rdata   (dreg_rdata)
	);

	// ==========================================================
	// Field helpers
	// Bits arrive LSB first, so shifting in from the top leaves the field's MSB at the top.
	assign instr_full = {debug_data_line_in, cur_reg.instr[INSTR_W-1]};          // see RQ10
	assign len_full   = {debug_data_line_in, cur_reg.len[LEN_W-1]};              // see RQ10
	assign sreg_in    = {debug_data_line_in, cur_reg.sreg[SHIFT_W-1:1]};         // see RQ10
	assign last_bit   = {1'b0, cur_reg.len, 3'b111};                             // see RQ4
	// A short field lands in the top bits; a long one gives only its top bits.
	assign link_wdata = cur_reg.sreg[SHIFT_W-1 -: DREG_W];                       // see RQ14
	assign done       = (ack_sync == cur_reg.req);
	assign sreg_lsb   = cur_reg.sreg[0];
	assign req_w      = cur_reg.req;
	assign sreg_low   = cur_reg.sreg[DREG_W-1:0];

	// ==========================================================
	// Frame state machine
	always_comb begin
		cur_next = cur_reg;
		unique case (cur_reg.st)
			L_IDLE: begin
				// Start strobe: claim the pin as an input.
				cur_next.st      = L_INSTR;                                       // see RQ1
				cur_next.cnt     = CNT_RST;
				cur_next.sreg    = SHIFT_RST;
				cur_next.oe      = 1'b0;
				cur_next.dout    = 1'b0;
				cur_next.claimed = 1'b1;
			end
			L_INSTR: begin
				cur_next.instr = instr_full;                                      // see RQ2
				cur_next.cnt   = CNT_W'(cur_reg.cnt + 1'b1);
				if (cur_reg.cnt == CNT_W'(INSTR_W - 1)) begin
					cur_next.cnt = CNT_RST;
					unique case (instr_full)                                      // see RQ16
						TDBG_INSTR_ADDR_WR: cur_next.st = L_ADDR_WR;
						TDBG_INSTR_ADDR_RD: begin
							cur_next.st   = L_ADDR_RD;
							cur_next.sreg = SHIFT_W'(cur_reg.addr);               // see RQ12
						end
						TDBG_INSTR_DATA_RD,
						TDBG_INSTR_DATA_WR: cur_next.st = L_LEN;                  // see RQ19
					endcase
				end
			end
			L_ADDR_WR: begin
				cur_next.sreg = sreg_in;
				cur_next.cnt  = CNT_W'(cur_reg.cnt + 1'b1);
				if (cur_reg.cnt == CNT_W'(ADDR_W - 1)) begin                      // see RQ5
					cur_next.addr = sreg_in[SHIFT_W-1 -: ADDR_W];                 // see RQ11
					cur_next.st   = L_STOP;
				end
			end
			L_ADDR_RD, L_DATA_RD: begin
				cur_next.oe   = 1'b1;                                             // see RQ20
				cur_next.dout = sreg_lsb;                                         // see RQ10
				cur_next.sreg = cur_reg.sreg >> 1;
				cur_next.cnt  = CNT_W'(cur_reg.cnt + 1'b1);
				if ((cur_reg.st == L_ADDR_RD && cur_reg.cnt == CNT_W'(ADDR_W - 1)) ||
				    (cur_reg.st == L_DATA_RD && cur_reg.cnt == last_bit)) begin   // see RQ7
					cur_next.st = L_STOP;
				end
			end
			L_LEN: begin
				cur_next.len = len_full;
				cur_next.cnt = CNT_W'(cur_reg.cnt + 1'b1);
				if (cur_reg.cnt == CNT_W'(LEN_W - 1)) begin
					cur_next.cnt = CNT_RST;
					if (cur_reg.instr == TDBG_INSTR_DATA_WR) begin
						cur_next.st = L_DATA_WR;                                  // see RQ19
					end else begin
						// Fetch starts at once so the wait is as short as possible.
						cur_next.st  = L_WAIT;                                    // see RQ15
						cur_next.req = !cur_reg.req;
					end
				end
			end
			L_DATA_WR: begin
				cur_next.sreg = sreg_in;
				cur_next.cnt  = CNT_W'(cur_reg.cnt + 1'b1);
				if (cur_reg.cnt == last_bit) begin                                // see RQ7
					cur_next.st  = L_WAIT;
					cur_next.req = !cur_reg.req;                                  // see RQ13
				end
			end
			L_WAIT: begin
				cur_next.oe  = 1'b1;                                              // see RQ8
				cur_next.cnt = CNT_RST;
				if (done) begin
					cur_next.dout = 1'b1;                                         // see RQ8
					if (cur_reg.instr == TDBG_INSTR_DATA_RD) begin
						cur_next.st   = L_DATA_RD;                                // see RQ17
						cur_next.sreg = SHIFT_W'(rdata_hold);                     // see RQ18
					end else begin
						cur_next.st = L_STOP;
					end
				end else begin
					cur_next.dout = 1'b0;                                         // see RQ9
				end
			end
			L_STOP: begin
				// Releasing on the stop edge returns the pin to its normal function.
				cur_next.oe      = 1'b0;                                          // see RQ3
				cur_next.dout    = 1'b0;
				cur_next.claimed = 1'b0;
				cur_next.st      = L_IDLE;
			end
			default: begin
				cur_next.st      = L_IDLE;
				cur_next.oe      = 1'b0;
				cur_next.claimed = 1'b0;
			end
		endcase
	end

	always_ff @(posedge debug_clock_line) begin
		if (!link_rstn) begin
			cur_reg      <= '0;
			cur_reg.st   <= L_IDLE;
			cur_reg.instr <= INSTR_RST;
			cur_reg.len  <= LEN_RST;
			cur_reg.cnt  <= CNT_RST;
			cur_reg.sreg <= SHIFT_RST;
			cur_reg.addr <= '0;                                                   // see RQ6
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign debug_data_line_out = cur_reg.dout;
	assign debug_data_line_oe  = cur_reg.oe;
	assign debug_port_claimed  = cur_reg.claimed;

	// ==========================================================
	// Assertions
	default clocking cb_link @(posedge debug_clock_line);
	endclocking
	default disable iff (!link_rstn);

	a_instr_addr_decode: assert property ( // see RQ16
		(cur_reg.st == L_INSTR && cur_reg.cnt == CNT_W'(1) && instr_full == TDBG_INSTR_ADDR_WR)
		|=> cur_reg.st == L_ADDR_WR)
		else $error("Address write code did not select the address write field.");

	a_stop_release: assert property ( // see RQ3
		cur_reg.st == L_STOP |=> !debug_data_line_oe && !debug_port_claimed && cur_reg.st == L_IDLE)
		else $error("Pin not released on the stop strobe.");

	a_len_data_end: assert property ( // see RQ4
		(cur_reg.st == L_DATA_WR && cur_reg.cnt == last_bit) |=> cur_reg.st == L_WAIT)
		else $error("Write data field length wrong.");

	a_data_within: assert property ( // see RQ7
		(cur_reg.st == L_DATA_WR || cur_reg.st == L_DATA_RD) |-> cur_reg.cnt <= last_bit)
		else $error("Data field overran its byte count.");

	a_addr_load_msb: assert property ( // see RQ11
		(cur_reg.st == L_ADDR_WR && cur_reg.cnt == CNT_W'(ADDR_W - 1))
		|=> cur_reg.st == L_STOP && cur_reg.addr[ADDR_W-1] == $past(debug_data_line_in))
		else $error("Address bits loaded out of order.");

	a_addr_reset_zero: assert property (disable iff (1'b0) // see RQ6
		!link_rstn |=> cur_reg.addr == '0)
		else $error("Address register not cleared by reset.");

	a_wait_zero: assert property ( // see RQ9
		(cur_reg.st == L_WAIT && !done) |=> debug_data_line_oe && !debug_data_line_out)
		else $error("Wait field ended before the access completed.");

	a_wait_one: assert property ( // see RQ8
		(cur_reg.st == L_WAIT && done)
		|=> debug_data_line_out && (cur_reg.st == L_STOP || cur_reg.st == L_DATA_RD))
		else $error("Wait field not terminated by a single one.");

	a_shift_lsb_first: assert property ( // see RQ10
		(cur_reg.st == L_ADDR_RD || cur_reg.st == L_DATA_RD)
		|=> debug_data_line_out == $past(sreg_lsb))
		else $error("Returned field not sent least significant bit first.");

	a_master_fields_quiet: assert property ( // see RQ20
		(cur_reg.st inside {L_INSTR, L_LEN, L_ADDR_WR, L_DATA_WR}) |-> !debug_data_line_oe)
		else $error("Device drove the data line during a master field.");

	a_read_request: assert property ( // see RQ17
		(cur_reg.st == L_LEN && cur_reg.cnt == CNT_W'(1) && cur_reg.instr == TDBG_INSTR_DATA_RD)
		|=> cur_reg.st == L_WAIT && req_w != $past(req_w))
		else $error("Read fetch not requested after the length field.");

	a_read_justify: assert property ( // see RQ18
		(cur_reg.st == L_WAIT && done && cur_reg.instr == TDBG_INSTR_DATA_RD)
		|=> sreg_low == $past(rdata_hold))
		else $error("Read data not right-justified.");

endmodule : tdbg_port

// ---- verilog/tdbg_sync.sv ----
// Purpose: Two flip-flop level synchroniser.
// Assumes: The input is a slowly changing level or a toggle.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module tdbg_sync
	import tdbg_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Level crossing in and out
	input  wire logic d,
	output logic      q
);

	typedef struct packed {
		logic s1;
		logic s2;
	} tdbg_sync_s;

	tdbg_sync_s cur_reg;
	tdbg_sync_s cur_next;

	always_comb begin
		cur_next    = cur_reg;
		cur_next.s1 = d;
		cur_next.s2 = cur_reg.s1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign q = cur_reg.s2;

endmodule : tdbg_sync
